// File: src/qam_pkg.sv
// Purpose: Shared constants and types for the mode control register bank
// Assumes: Serial frame of 16 bits, flag first, address next, data last
// Notes: Addresses are register indices on the serial port
package qam_pkg;

    localparam int FRAME_BITS = 16;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam logic [6:0] ADDR_FORMAT = 7'h01;
    localparam logic [6:0] ADDR_OUTPUT = 7'h02;
    localparam logic [6:0] ADDR_PAT_HI = 7'h03;
    localparam logic [6:0] ADDR_PAT_LO = 7'h04;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    localparam int RESET_BIT_POS = 7;

    // Format and power register fields
    localparam int STAB_DIS_POS = 7;
    localparam int SCRAMBLE_POS = 6;
    localparam int SIGNED_POS = 5;
    localparam int SLEEP_POS = 4;
    // Output mode register fields
    localparam int CUR_MSB = 7;
    localparam int CUR_LSB = 5;
    localparam int TERM_POS = 4;
    localparam int OUT_DIS_POS = 3;
    localparam int LANE_MSB = 2;
    localparam int LANE_LSB = 0;
    // Pattern high register fields
    localparam int PAT_EN_POS = 7;
    localparam int PAT_UP_MSB = 5;

    // Driver current in units of 0.25 mA; doubled when terminated
    localparam logic [4:0] CUR_Q_3P5 = 5'h0e;
    localparam logic [4:0] CUR_Q_4P0 = 5'h10;
    localparam logic [4:0] CUR_Q_4P5 = 5'h12;
    localparam logic [4:0] CUR_Q_3P0 = 5'h0c;
    localparam logic [4:0] CUR_Q_2P5 = 5'h0a;
    localparam logic [4:0] CUR_Q_2P1 = 5'h08;
    localparam logic [4:0] CUR_Q_1P75 = 5'h07;

    typedef struct packed {
        logic stabilizer_disable;
        logic output_scramble_enable;
        logic signed_format_select;
        logic sleep_all;
        logic [3:0] channel_nap;
        logic [2:0] driver_current_select;
        logic internal_termination_enable;
        logic digital_output_disable;
        logic [2:0] lane_serialization_select;
        logic pattern_output_enable;
        logic [13:0] test_pattern;
    } qam_mode_t;

    typedef struct packed {
        logic two_lanes;
        logic [4:0] serial_bits;
        logic code_valid;
        logic [5:0] driver_qma;
        logic current_valid;
    } qam_output_cfg_t;

endpackage

// File: src/qam_mode_decode.sv
// Purpose: Decodes the stored output mode fields into driver settings
// Assumes: Pure combinational use inside the register bank
// Notes: Unused codes flag themselves invalid instead of guessing
`timescale 1ns/1ps
module qam_mode_decode
    import qam_pkg::*;
(
    input wire logic [7:0] out_mode,
    output qam_pkg::qam_output_cfg_t cfg
);
    import qam_pkg::*;
    logic [4:0] base_q;

    always_comb
    begin
        cfg = '0;
        base_q = 5'h00;
        cfg.current_valid = 1'b1;
        case (out_mode[CUR_MSB:CUR_LSB]) // RULE_07
            3'h0: base_q = CUR_Q_3P5;
            3'h1: base_q = CUR_Q_4P0;
            3'h2: base_q = CUR_Q_4P5;
            3'h4: base_q = CUR_Q_3P0;
            3'h5: base_q = CUR_Q_2P5;
            3'h6: base_q = CUR_Q_2P1;
            3'h7: base_q = CUR_Q_1P75;
            default: cfg.current_valid = 1'b0;
        endcase
        // Termination doubles the drive
        cfg.driver_qma = out_mode[TERM_POS] ? {base_q, 1'b0} : {1'b0, base_q}; // RULE_08
        cfg.code_valid = 1'b1;
        case (out_mode[LANE_MSB:LANE_LSB]) // RULE_11
            3'h0: {cfg.two_lanes, cfg.serial_bits} = {1'b1, 5'h10};
            3'h1: {cfg.two_lanes, cfg.serial_bits} = {1'b1, 5'h0e};
            3'h2: {cfg.two_lanes, cfg.serial_bits} = {1'b1, 5'h0c};
            3'h5: {cfg.two_lanes, cfg.serial_bits} = {1'b0, 5'h0e};
            3'h6: {cfg.two_lanes, cfg.serial_bits} = {1'b0, 5'h0c};
            3'h7: {cfg.two_lanes, cfg.serial_bits} = {1'b0, 5'h10};
            default:
            begin
                cfg.two_lanes = 1'b0;
                cfg.serial_bits = 5'h00;
                cfg.code_valid = 1'b0;
            end
        endcase
    end
endmodule // qam_mode_decode

// File: src/qam_mode_regs.sv
// Purpose: Serial-port mode control register bank for a four-channel converter
// Assumes: Serial pins come from another domain and are synchronised to clk_sys
// Notes: Serial clock must be well below a quarter of clk_sys
//
// How it works
// (RULE_01) Format bit 7 high turns the clock duty stabilizer off.
// (RULE_02) Format bit 6 high enables the output data randomizer.
// (RULE_03) Format bit 5 selects offset binary (0) or two's complement (1).
// (RULE_04) Format bit 4 high sleeps all channels, ignoring nap bits.
// (RULE_05) With sleep clear, bits 0 to 3 nap channels 1 to 4.
// (RULE_06) Any combination of nap bits naps those channels independently.
// (RULE_07) Output bits 7 to 5 choose driver current; code 011 unused.
// (RULE_08) Output bit 4 enables termination and doubles driver current.
// (RULE_09) Host enables termination only with the three lowest currents.
// (RULE_10) Output bit 3 high disables all digital outputs.
// (RULE_11) Output bits 2 to 0 choose lanes and serialization width.
// (RULE_12) Pattern high bit 7 replaces converted data with the test pattern.
// (RULE_13) Pattern high bits 5 to 0 give pattern bits 13 to 8.
// (RULE_14) Pattern high bit 6 has no effect on the device.
// (RULE_15) Pattern low byte gives pattern bits 7 to 0.
// (RULE_16) Access is a 16-bit frame: flag, 7-bit address, 8 data bits.
// (RULE_17) Software reset clears every mode register to zero.
// (RULE_18) Readback returns stored bytes unchanged, don't-care bits included.
`timescale 1ns/1ps
module qam_mode_regs
    import qam_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic cs_n_pin,
    input wire logic sck_pin,
    input wire logic sdi_pin,
    output logic sdo_o,
    output logic sdo_oe,
    output qam_pkg::qam_mode_t mode,
    output logic stabilizer_off,
    output logic [3:0] channel_off,
    output logic sleep_active,
    output logic outputs_enabled,
    output logic [1:0] active_lanes,
    output logic [4:0] serial_width,
    output logic [5:0] driver_qma,
    output logic termination_on,
    output logic mode_code_valid
);
    import qam_pkg::*;

    logic [1:0] cs_sync_r;
    logic [1:0] sck_sync_r;
    logic [1:0] sdi_sync_r;
    logic sck_prev_r;
    logic cs_prev_r;
    logic [4:0] bit_cnt_r;
    logic [15:0] shift_r;
    logic read_frame_r;
    logic [7:0] format_power_control_r;
    logic [7:0] output_driver_mode_r;
    logic [7:0] pattern_high_and_enable_r;
    logic [7:0] pattern_low_byte_r;
    logic [7:0] read_byte_r;
    logic sdo_o_r;
    logic sdo_oe_r;
    qam_mode_t mode_r;
    qam_mode_t mode_nxt;
    qam_output_cfg_t out_cfg;
    logic sck_rise;
    logic sck_fall;
    logic frame_end;
    logic cs_active;
    logic soft_reset_req;
    logic write_commit;
    logic [3:0] reg_sel;
    wire logic [3:0] channel_off_nxt;

    function automatic logic [7:0] read_mux(input logic [6:0] addr, input logic [7:0] r1, input logic [7:0] r2,
                                            input logic [7:0] r3, input logic [7:0] r4);
        if (addr == ADDR_FORMAT)
            return r1;
        else if (addr == ADDR_OUTPUT)
            return r2;
        else if (addr == ADDR_PAT_HI)
            return r3;
        else if (addr == ADDR_PAT_LO)
            return r4;
        else
            return REG_RESET_VAL;
    endfunction

    // One-hot register select for the write path
    function automatic logic [3:0] reg_select(input logic [6:0] addr);
        if (addr == ADDR_FORMAT)
            return 4'h1;
        else if (addr == ADDR_OUTPUT)
            return 4'h2;
        else if (addr == ADDR_PAT_HI)
            return 4'h4;
        else if (addr == ADDR_PAT_LO)
            return 4'h8;
        else
            return 4'h0;
    endfunction

    // Two flops on every pin before use
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            cs_sync_r <= 2'h3;
            sck_sync_r <= 2'h0;
            sdi_sync_r <= 2'h0;
        end
        else
        begin
            cs_sync_r <= {cs_sync_r[0], cs_n_pin};
            sck_sync_r <= {sck_sync_r[0], sck_pin};
            sdi_sync_r <= {sdi_sync_r[0], sdi_pin};
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            sck_prev_r <= 1'b0;
            cs_prev_r <= 1'b1;
        end
        else
        begin
            sck_prev_r <= sck_sync_r[1];
            cs_prev_r <= cs_sync_r[1];
        end
    end

    assign cs_active = ~cs_sync_r[1];
    assign sck_rise = cs_active & sck_sync_r[1] & ~sck_prev_r;
    assign sck_fall = cs_active & ~sck_sync_r[1] & sck_prev_r;
    // Write commits only at the rising edge of chip select
    assign frame_end = cs_sync_r[1] & ~cs_prev_r;

    // Frame shift register; edges past the sixteenth are dropped
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            bit_cnt_r <= 5'h00;
            shift_r <= 16'h0000;
        end
        else if (!cs_active)
        begin
            bit_cnt_r <= 5'h00;
        end
        else if (sck_rise && bit_cnt_r < 5'(FRAME_BITS)) // RULE_16
        begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
            shift_r <= {shift_r[14:0], sdi_sync_r[1]};
        end
    end

    // Flag high on the first bit marks a readback frame
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            read_frame_r <= 1'b0;
        else if (!cs_active)
            read_frame_r <= 1'b0;
        else if (sck_rise && bit_cnt_r == 5'h00)
            read_frame_r <= sdi_sync_r[1]; // RULE_16
    end

    // A write needs all sixteen bits seen and a low flag
    assign write_commit = frame_end && bit_cnt_r == 5'(FRAME_BITS) && !shift_r[15]; // RULE_16
    assign reg_sel = reg_select(shift_r[14:8]);
    // Reset register is write-only and keeps no bits
    assign soft_reset_req = write_commit && shift_r[14:8] == ADDR_RESET && shift_r[RESET_BIT_POS]; // RULE_17

    // Stored bytes; don't-care bits are kept as written
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            format_power_control_r <= REG_RESET_VAL;
            output_driver_mode_r <= REG_RESET_VAL;
            pattern_high_and_enable_r <= REG_RESET_VAL;
            pattern_low_byte_r <= REG_RESET_VAL;
        end
        else if (soft_reset_req)
        begin
            format_power_control_r <= REG_RESET_VAL; // RULE_17
            output_driver_mode_r <= REG_RESET_VAL; // RULE_17
            pattern_high_and_enable_r <= REG_RESET_VAL; // RULE_17
            pattern_low_byte_r <= REG_RESET_VAL; // RULE_17
        end
        else if (write_commit) // RULE_16
        begin
            if (reg_sel[0])
                format_power_control_r <= shift_r[7:0];
            else if (reg_sel[1])
                output_driver_mode_r <= shift_r[7:0];
            else if (reg_sel[2])
                pattern_high_and_enable_r <= shift_r[7:0];
            else if (reg_sel[3])
                pattern_low_byte_r <= shift_r[7:0];
        end
    end

    // Readback: byte loaded after the address, shifted on falling edges
    // Loaded on the last address edge so D7 stands before the first fall
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            read_byte_r <= 8'h00;
        else if (sck_rise && bit_cnt_r == 5'h07 && read_frame_r)
            read_byte_r <= read_mux({shift_r[5:0], sdi_sync_r[1]}, format_power_control_r, output_driver_mode_r,
                                    pattern_high_and_enable_r, pattern_low_byte_r); // RULE_18
        else if (sck_fall && bit_cnt_r > 5'h08 && bit_cnt_r <= 5'(FRAME_BITS))
            read_byte_r <= {read_byte_r[6:0], 1'b0};
    end

    // Open drain: drive low only for a zero data bit
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            sdo_o_r <= 1'b0;
            sdo_oe_r <= 1'b0;
        end
        else if (read_frame_r && cs_active && bit_cnt_r >= 5'h08 && bit_cnt_r < 5'(FRAME_BITS))
        begin
            sdo_o_r <= 1'b0;
            sdo_oe_r <= ~read_byte_r[7];
        end
        else
        begin
            sdo_o_r <= 1'b0;
            sdo_oe_r <= 1'b0;
        end
    end

    always_comb
    begin
        mode_nxt.stabilizer_disable = format_power_control_r[STAB_DIS_POS]; // RULE_01
        mode_nxt.output_scramble_enable = format_power_control_r[SCRAMBLE_POS]; // RULE_02
        mode_nxt.signed_format_select = format_power_control_r[SIGNED_POS]; // RULE_03
        mode_nxt.sleep_all = format_power_control_r[SLEEP_POS]; // RULE_04
        mode_nxt.channel_nap = format_power_control_r[3:0]; // RULE_06
        mode_nxt.driver_current_select = output_driver_mode_r[CUR_MSB:CUR_LSB]; // RULE_07
        mode_nxt.internal_termination_enable = output_driver_mode_r[TERM_POS]; // RULE_08
        mode_nxt.digital_output_disable = output_driver_mode_r[OUT_DIS_POS]; // RULE_10
        mode_nxt.lane_serialization_select = output_driver_mode_r[LANE_MSB:LANE_LSB]; // RULE_11
        mode_nxt.pattern_output_enable = pattern_high_and_enable_r[PAT_EN_POS]; // RULE_12
        // Bit 6 of the high byte is never read here
        mode_nxt.test_pattern = {pattern_high_and_enable_r[PAT_UP_MSB:0], pattern_low_byte_r}; // RULE_13 RULE_14 RULE_15
    end

    qam_mode_decode u_decode (
        .out_mode(output_driver_mode_r),
        .cfg(out_cfg)
    );

    // Nap vector: one gate per channel, sleep wins over every nap
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1)
        begin : g_chan_power
            assign channel_off_nxt[ch] = mode_nxt.sleep_all | mode_nxt.channel_nap[ch]; // RULE_04 RULE_05 RULE_06
        end
    endgenerate

    // Registered copy so every mode output leaves a flop
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            mode_r <= '0;
        else
            mode_r <= mode_nxt;
    end

    // Per-channel power state; sleep overrides every nap
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            channel_off <= 4'h0;
            sleep_active <= 1'b0;
            stabilizer_off <= 1'b0;
        end
        else
        begin
            sleep_active <= mode_nxt.sleep_all; // RULE_04
            stabilizer_off <= mode_nxt.stabilizer_disable; // RULE_01
            channel_off <= channel_off_nxt; // RULE_04 RULE_05 RULE_06
        end
    end

    // Lane count and width; unused codes show zero lanes
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            active_lanes <= 2'h2;
            serial_width <= 5'h10;
        end
        else
        begin
            active_lanes <= out_cfg.two_lanes ? 2'h2 : (out_cfg.code_valid ? 2'h1 : 2'h0); // RULE_11
            serial_width <= out_cfg.serial_bits; // RULE_11
        end
    end

    // Drive strength; the host must keep termination to the low currents
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            driver_qma <= {1'b0, CUR_Q_3P5};
            termination_on <= 1'b0;
        end
        else
        begin
            driver_qma <= out_cfg.driver_qma; // RULE_08
            termination_on <= mode_nxt.internal_termination_enable; // RULE_08
        end
    end

    // Output enable follows the disable bit inverted
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            outputs_enabled <= 1'b1;
        else
            outputs_enabled <= ~mode_nxt.digital_output_disable; // RULE_10
    end

    // Flags a lane or current code that selects nothing
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            mode_code_valid <= 1'b1;
        else
            mode_code_valid <= out_cfg.code_valid & out_cfg.current_valid; // RULE_07 RULE_11
    end

    assign mode = mode_r;
    assign sdo_o = sdo_o_r;
    assign sdo_oe = sdo_oe_r;
endmodule // qam_mode_regs

// File: tb/qam_mode_regs_properties.sv
// Purpose: Port-level checks for the mode control register bank
// Assumes: Derived outputs update on the same clock edge as the registered mode
// Notes: Runs of 8 cycles cover the serial sync and commit delay
`timescale 1ns/1ps
module qam_mode_regs_props
    import qam_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic cs_n_pin,
    input wire logic sdo_oe,
    input qam_pkg::qam_mode_t mode,
    input wire logic stabilizer_off,
    input wire logic [3:0] channel_off,
    input wire logic sleep_active,
    input wire logic outputs_enabled,
    input wire logic [1:0] active_lanes,
    input wire logic [4:0] serial_width,
    input wire logic [5:0] driver_qma,
    input wire logic termination_on,
    input wire logic mode_code_valid
);
    import qam_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    qam_mode_t mode_d1_r, mode_d2_r;
    logic steady;
    // Derived outputs register alongside the mode; judge them only once it has settled
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            {mode_d1_r, mode_d2_r} <= '0;
        else
            {mode_d1_r, mode_d2_r} <= {mode, mode_d1_r};
    end
    assign steady = (mode == mode_d1_r) && (mode_d1_r == mode_d2_r);
    sequence s_frame_open; !cs_n_pin [*8]; endsequence
    sequence s_port_idle; cs_n_pin [*8]; endsequence
    property p_stab_off; steady |-> stabilizer_off == mode.stabilizer_disable; endproperty
    a_stab_off: assert property (p_stab_off) else $error("stabilizer off wrong");
    property p_sleep; steady && mode.sleep_all |-> channel_off == 4'hf && sleep_active; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep wrong");
    property p_nap; steady && !mode.sleep_all |-> channel_off == mode.channel_nap; endproperty
    a_nap: assert property (p_nap) else $error("nap wrong");
    property p_cur_code; steady && mode.driver_current_select == 3'h3 |-> driver_qma == 6'h00 && !mode_code_valid; endproperty
    a_cur_code: assert property (p_cur_code) else $error("unused current code wrong");
    property p_term_double; steady && mode.driver_current_select == 3'h7 |->
        driver_qma == (mode.internal_termination_enable ? 6'h0e : 6'h07) && termination_on == mode.internal_termination_enable;
    endproperty
    a_term_double: assert property (p_term_double) else $error("termination current wrong");
    property p_out_dis; steady |-> outputs_enabled == !mode.digital_output_disable; endproperty
    a_out_dis: assert property (p_out_dis) else $error("output disable wrong");
    property p_one_lane; steady && mode.lane_serialization_select == 3'h5 |-> active_lanes == 2'h1 && serial_width == 5'h0e; endproperty
    a_one_lane: assert property (p_one_lane) else $error("lane mode wrong");
    property p_frame_hold; s_frame_open |-> $stable(mode); endproperty
    a_frame_hold: assert property (p_frame_hold) else $error("mode changed inside frame");
    property p_sdo_idle; s_port_idle |-> !sdo_oe; endproperty
    a_sdo_idle: assert property (p_sdo_idle) else $error("sdo driven while idle");
    property p_reset_clear; $fell(reset) |-> mode == '0 && outputs_enabled; endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong");
endmodule // qam_mode_regs_props
bind qam_mode_regs qam_mode_regs_props i_qam_mode_regs_props (.clk_sys(clk_sys), .reset(reset),
    .cs_n_pin(cs_n_pin), .sdo_oe(sdo_oe), .mode(mode), .stabilizer_off(stabilizer_off), .channel_off(channel_off),
    .sleep_active(sleep_active), .outputs_enabled(outputs_enabled), .active_lanes(active_lanes),
    .serial_width(serial_width), .driver_qma(driver_qma), .termination_on(termination_on),
    .mode_code_valid(mode_code_valid));

// File: tb/qam_spi_host.sv
// Purpose: Serial configuration host that frames register accesses
// Assumes: SDO is open drain with a pull-up on the board
// Notes: Half periods of 6 clocks leave room for the 2-flop sync
`timescale 1ns/1ps
module qam_spi_host
(
    input wire logic clk_sys,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    output logic cs_n_pin,
    output logic sck_pin,
    output logic sdi_pin
);
    logic sdo_wire;
    assign sdo_wire = sdo_oe ? sdo_o : 1'b1;
    initial
    begin
        cs_n_pin = 1'b1;
        sck_pin = 1'b0;
        sdi_pin = 1'b0;
    end
    // Fewer than 16 bits gives a short frame; clock stays low outside frames
    task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] q);
        q = 8'h00;
        @(posedge clk_sys);
        cs_n_pin <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_sys);
            sdi_pin <= w[15 - i];
            repeat (5) @(posedge clk_sys);
            sck_pin <= 1'b1;
            if (i >= 8)
                q = {q[6:0], sdo_wire};
            repeat (6) @(posedge clk_sys);
            sck_pin <= 1'b0;
        end
        repeat (5) @(posedge clk_sys);
        cs_n_pin <= 1'b1;
        // Released line must not keep the last bit
        sdi_pin <= ~sdi_pin;
        repeat (12) @(posedge clk_sys);
    endtask
endmodule // qam_spi_host

// File: tb/qam_mode_regs_test.sv
// Purpose: Self-checking bench for the mode control register bank
// Assumes: Host model frames each access; checker is bound to the bank
// Notes: Host idle time after a frame covers commit plus decode delay
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module qam_mode_regs_test;
    import qam_pkg::*;
    typedef struct packed {
        logic [6:0] a;
        logic [7:0] d;
        logic [3:0] off;
        logic [5:0] qma;
        logic [4:0] w;
    } qam_row_t;
    logic clk_sys, reset, cs_n_pin, sck_pin, sdi_pin, sdo_o, sdo_oe, stabilizer_off, sleep_active;
    logic outputs_enabled, termination_on, mode_code_valid;
    logic [3:0] channel_off;
    logic [1:0] active_lanes;
    logic [4:0] serial_width;
    logic [5:0] driver_qma;
    logic [7:0] rd;
    qam_mode_t mode;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    // Row 12 uses the lowest current with termination, as the host must
    qam_row_t rows [15] = '{{7'h01, 8'h00, 4'h0, 6'h0e, 5'h10}, {7'h01, 8'h05, 4'h5, 6'h0e, 5'h10},
        {7'h01, 8'h1a, 4'hf, 6'h0e, 5'h10}, {7'h01, 8'he9, 4'h9, 6'h0e, 5'h10}, {7'h02, 8'h00, 4'h9, 6'h0e, 5'h10},
        {7'h02, 8'h21, 4'h9, 6'h10, 5'h0e}, {7'h02, 8'h42, 4'h9, 6'h12, 5'h0c}, {7'h02, 8'h63, 4'h9, 6'h00, 5'h00},
        {7'h02, 8'h84, 4'h9, 6'h0c, 5'h00}, {7'h02, 8'ha5, 4'h9, 6'h0a, 5'h0e}, {7'h02, 8'hc6, 4'h9, 6'h08, 5'h0c},
        {7'h02, 8'he7, 4'h9, 6'h07, 5'h10}, {7'h02, 8'hf8, 4'h9, 6'h0e, 5'h10}, {7'h03, 8'hc5, 4'h9, 6'h0e, 5'h10},
        {7'h04, 8'h3c, 4'h9, 6'h0e, 5'h10}};
    qam_mode_regs i_qam_mode_regs (.clk_sys(clk_sys), .reset(reset), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
        .sdi_pin(sdi_pin), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .mode(mode), .stabilizer_off(stabilizer_off),
        .channel_off(channel_off), .sleep_active(sleep_active), .outputs_enabled(outputs_enabled),
        .active_lanes(active_lanes), .serial_width(serial_width), .driver_qma(driver_qma),
        .termination_on(termination_on), .mode_code_valid(mode_code_valid));
    qam_spi_host i_qam_spi_host (.clk_sys(clk_sys), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .cs_n_pin(cs_n_pin),
        .sck_pin(sck_pin), .sdi_pin(sdi_pin));
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic acc(input logic r, input logic [6:0] a, input logic [7:0] d);
        i_qam_spi_host.xfer({r, a, d}, 16, rd);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // About 44 frames of at most 210 cycles each
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_total++;
            summarize();
        end
    end
    initial
    begin
        reset = 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        acc(1'b0, ADDR_RESET, 8'h80);
        foreach (rows[i])
        begin
            acc(1'b0, rows[i].a, rows[i].d);
            acc(1'b1, rows[i].a, 8'h00);
            `CHK("readback", rows[i].d, rd)
            `CHK("channel_off", rows[i].off, channel_off)
            `CHK("driver_qma", rows[i].qma, driver_qma)
            `CHK("serial_width", rows[i].w, serial_width)
        end
        $display("test table done");
        `CHK("fmt_bits", 3'h7, {stabilizer_off, mode.output_scramble_enable, mode.signed_format_select})
        `CHK("outputs_enabled", 1'b0, outputs_enabled)
        `CHK("termination_on", 1'b1, termination_on)
        `CHK("active_lanes", 2'h2, active_lanes)
        `CHK("code_valid", 1'b1, mode_code_valid)
        `CHK("pattern", 15'h453c, {mode.pattern_output_enable, mode.test_pattern})
        acc(1'b0, ADDR_PAT_HI, 8'h45);
        `CHK("pattern_off", 15'h053c, {mode.pattern_output_enable, mode.test_pattern})
        $display("test fields done");
        acc(1'b1, ADDR_PAT_LO, 8'hff);
        i_qam_spi_host.xfer({1'b0, ADDR_PAT_LO, 8'h00}, 12, rd);
        acc(1'b0, 7'h10, 8'h5a);
        acc(1'b1, ADDR_PAT_LO, 8'h00);
        `CHK("pat_lo_kept", 8'h3c, rd)
        acc(1'b1, 7'h10, 8'h00);
        `CHK("unmapped", 8'h00, rd)
        $display("test refusals done");
        acc(1'b0, ADDR_RESET, 8'h80);
        for (int a = 1; a < 5; a++)
        begin
            acc(1'b1, 7'(a), 8'h00);
            `CHK("soft_reset", REG_RESET_VAL, rd)
        end
        `CHK("driver_after", 6'h0e, driver_qma)
        $display("test soft reset done");
        acc(1'b0, ADDR_FORMAT, 8'h13);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        #1;
        `CHK("hard_reset", 5'h00, {mode.sleep_all, channel_off})
        acc(1'b0, ADDR_FORMAT, 8'h13);
        `CHK("sleep", 5'h1f, {sleep_active, channel_off})
        $display("test hard reset done");
        summarize();
    end
endmodule // qam_mode_regs_test
